// *** hw/lpi_defines.svh ***
`ifndef LPI_DEFINES_SVH
`define LPI_DEFINES_SVH

`define LPI_ADDR_MASTER    8'h0E
`define LPI_ADDR_INT_FIRST 8'h10
`define LPI_ADDR_INT_LAST  8'h17
`define LPI_MASTER_RESET   8'h00
`define LPI_INT_RESET      8'h00
`define LPI_RD_UNMAPPED    8'h00

`define LPI_MST_HI 7
`define LPI_MST_LO 4
`define LPI_GLB_HI 3
`define LPI_GLB_LO 0

`define LPI_STATIC_NIB 4'hF
`define LPI_MST_OFF    4'h0
`define LPI_LAST_SLOT  4'hE
`define LPI_LAST_CYC   4'hF

`define LPI_CLK_HZ      20000000
`define LPI_OSC_HZ      32000
`define LPI_STEP_CYCLES (`LPI_CLK_HZ / `LPI_OSC_HZ)
`define LPI_PRE_W       10

`define LPI_NUM_OUT  17
`define LPI_NUM_IREG 8
`define LPI_EXTRA_IX 16

`endif

// *** hw/lpi_pkg.sv ***
`include "lpi_defines.svh"

package lpi_pkg;

  typedef logic [3:0]                lpi_nib_t;
  typedef logic [`LPI_NUM_OUT-1:0]   lpi_bits_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lpi_reg_req_s;

  typedef struct packed {
    logic      enable;
    logic      flip;
    lpi_bits_t phase0;
    lpi_bits_t phase1;
  } lpi_blink_s;

  typedef struct packed {
    logic [`LPI_PRE_W-1:0]           prescale;
    lpi_nib_t                        slot;
    lpi_nib_t                        cyc;
    logic                            running;
    lpi_nib_t                        sh_master;
    lpi_nib_t [`LPI_NUM_OUT-1:0]     sh_int;
    lpi_bits_t                       sh_level;
    logic [7:0]                      master;
    logic [`LPI_NUM_IREG-1:0][7:0]   int_regs;
    lpi_bits_t                       pin_oe;
    lpi_bits_t                       pin_out;
    logic [7:0]                      rd_data;
  } lpi_state_s;

endpackage

// *** hw/lpi_top.sv ***
// Functional notes
// - Master nibble zero: all outputs static
// - Eight intensity registers, ignored when overridden
// - Field 0xF static, 0x0-0xE PWM
// - Global flag: master register sole source
// - Level 0: low (n+1)/16; level 1 swapped
// - Setting 0xF holds level bit statically
// - Blink picks level from active phase set
// - Extra output nibble doubles as global value
// - Global replaces all seventeen settings
// - Global flag selects; clearing restores individual
// - Master plus global give 240 steps
// - Global mode applies to all ports
// - Period 240 steps, 15 slots of 16
// - Outside gated slots output stays off
// - Master zero stops the oscillator
// - Steps from 32kHz tick, only when running
`timescale 1ns/1ps
`default_nettype none
`include "lpi_defines.svh"

module lpi_top (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire lpi_pkg::lpi_reg_req_s reg_req,
  input  wire logic                 global_enable,
  input  wire lpi_pkg::lpi_blink_s  blink,
  output logic [7:0]                reg_rd_data,
  output logic [`LPI_NUM_OUT-1:0]   pin_out,
  output logic [`LPI_NUM_OUT-1:0]   pin_oe,
  output logic                      osc_run
);

  localparam logic [`LPI_PRE_W-1:0] STEP_LAST =
    `LPI_PRE_W'(`LPI_STEP_CYCLES - 1);

  lpi_pkg::lpi_state_s state_reg;
  lpi_pkg::lpi_state_s state_next;
  lpi_pkg::lpi_bits_t  level_live;
  lpi_pkg::lpi_nib_t   mst_live;
  logic                tick;
  logic                boundary;

  // Output 16 always reads the shared nibble; the rest only in global mode
  function automatic lpi_pkg::lpi_nib_t eff_int(
    input logic [7:0]                    mreg,
    input logic [`LPI_NUM_IREG-1:0][7:0] iregs,
    input logic                          glb,
    input int                            idx
  );
    logic [7:0] pair;
    pair = iregs[3'(idx / 2)];
    if (glb || idx == `LPI_EXTRA_IX) begin
      return mreg[`LPI_GLB_HI:`LPI_GLB_LO];
    end else if (idx % 2 == 1) begin
      return pair[7:4];
    end else begin
      return pair[3:0];
    end
  endfunction

  // Value the pin shows: 1 releases, 0 sinks
  function automatic logic pin_value(
    input logic              run,
    input lpi_pkg::lpi_nib_t slot,
    input lpi_pkg::lpi_nib_t cyc,
    input lpi_pkg::lpi_nib_t mst,
    input lpi_pkg::lpi_nib_t n,
    input logic              lvl
  );
    if (!run || n == `LPI_STATIC_NIB) begin
      return lvl;
    end else if (slot < mst && cyc <= n) begin
      return lvl;
    end else begin
      return ~lvl;
    end
  endfunction

  function automatic logic is_int_addr(input logic [7:0] a);
    return a >= `LPI_ADDR_INT_FIRST && a <= `LPI_ADDR_INT_LAST;
  endfunction

  assign mst_live = state_reg.master[`LPI_MST_HI:`LPI_MST_LO];
  assign level_live = (blink.enable && blink.flip) ? blink.phase1 : blink.phase0;
  assign tick = state_reg.prescale == STEP_LAST;
  // Stopped: shadows track live values so static outputs follow at once
  assign boundary = !state_reg.running ||
    (tick && state_reg.cyc == `LPI_LAST_CYC && state_reg.slot == `LPI_LAST_SLOT);

  always_comb begin
    logic [2:0] ix;
    ix = 3'h0;
    state_next = state_reg;

    // Register writes
    if (reg_req.wr) begin
      if (reg_req.addr == `LPI_ADDR_MASTER) begin
        state_next.master = reg_req.wdata;
      end else if (is_int_addr(reg_req.addr)) begin
        ix = reg_req.addr[2:0];
        state_next.int_regs[ix] = reg_req.wdata;
      end
    end

    // Registered read-back of stored values
    if (reg_req.addr == `LPI_ADDR_MASTER) begin
      state_next.rd_data = state_reg.master;
    end else if (is_int_addr(reg_req.addr)) begin
      state_next.rd_data = state_reg.int_regs[reg_req.addr[2:0]];
    end else begin
      state_next.rd_data = `LPI_RD_UNMAPPED;
    end

    // Step timebase; held at zero when master is off
    if (mst_live == `LPI_MST_OFF) begin
      state_next.running  = 1'b0;
      state_next.prescale = '0;
      state_next.slot     = 4'h0;
      state_next.cyc      = 4'h0;
    end else if (!state_reg.running) begin
      state_next.running  = 1'b1;
      state_next.prescale = '0;
      state_next.slot     = 4'h0;
      state_next.cyc      = 4'h0;
    end else if (tick) begin
      state_next.prescale = '0;
      state_next.cyc      = state_reg.cyc + 4'h1;
      if (state_reg.cyc == `LPI_LAST_CYC) begin
        if (state_reg.slot == `LPI_LAST_SLOT) begin
          state_next.slot = 4'h0;
        end else begin
          state_next.slot = state_reg.slot + 4'h1;
        end
      end
    end else begin
      state_next.prescale = state_reg.prescale + `LPI_PRE_W'(1);
    end

    // Rewrites land only between periods, avoiding runt pulses
    if (boundary) begin
      state_next.sh_master = mst_live;
      state_next.sh_level  = level_live;
      for (int i = 0; i < `LPI_NUM_OUT; i++) begin
        state_next.sh_int[i] =
          eff_int(state_reg.master, state_reg.int_regs, global_enable, i);
      end
    end

    // Open drain: enable sinks the pin
    state_next.pin_out = '0;
    for (int i = 0; i < `LPI_NUM_OUT; i++) begin
      state_next.pin_oe[i] = ~pin_value(state_reg.running, state_reg.slot,
        state_reg.cyc, state_reg.sh_master, state_reg.sh_int[i],
        state_reg.sh_level[i]);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.master <= `LPI_MASTER_RESET;
      state_reg.int_regs <= {`LPI_NUM_IREG{`LPI_INT_RESET}};
      state_reg.pin_oe <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rd_data = state_reg.rd_data;
  assign pin_oe      = state_reg.pin_oe;
  assign pin_out     = state_reg.pin_out;
  assign osc_run     = state_reg.running;

  sequence s_stopped;
    !state_reg.running [*3];
  endsequence

  property p_static_off;
    @(posedge clk) disable iff (reset)
    s_stopped |-> pin_oe == ~$past(level_live, 2);
  endproperty
  a_static_off: assert property (p_static_off)
    else $error("pins not static while master off");

  property p_osc_stop;
    @(posedge clk) disable iff (reset)
    mst_live == `LPI_MST_OFF |=> !osc_run && state_reg.prescale == '0;
  endproperty
  a_osc_stop: assert property (p_osc_stop)
    else $error("oscillator runs with master off");

  property p_slot_range;
    @(posedge clk) disable iff (reset)
    state_reg.slot <= `LPI_LAST_SLOT;
  endproperty
  a_slot_range: assert property (p_slot_range)
    else $error("timeslot beyond fifteen");

  property p_step_tick;
    @(posedge clk) disable iff (reset)
    state_reg.running && $past(state_reg.running) && $changed(state_reg.cyc)
      |-> $past(state_reg.prescale) == STEP_LAST;
  endproperty
  a_step_tick: assert property (p_step_tick)
    else $error("step advanced off the oscillator tick");

  property p_period_latch;
    @(posedge clk) disable iff (reset)
    state_reg.running && $past(state_reg.running) &&
      ($changed(state_reg.sh_int) || $changed(state_reg.sh_level))
      |-> $past(boundary);
  endproperty
  a_period_latch: assert property (p_period_latch)
    else $error("setting applied mid period");

  property p_gate_off;
    @(posedge clk) disable iff (reset)
    state_reg.running && state_reg.slot >= state_reg.sh_master &&
      state_reg.sh_int[2] != `LPI_STATIC_NIB
      |=> pin_oe[2] == $past(state_reg.sh_level[2]);
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("output active outside gated slot");

  property p_duty_on;
    @(posedge clk) disable iff (reset)
    state_reg.running && state_reg.slot < state_reg.sh_master &&
      state_reg.sh_int[2] != `LPI_STATIC_NIB &&
      state_reg.cyc <= state_reg.sh_int[2]
      |=> pin_oe[2] == ~$past(state_reg.sh_level[2]);
  endproperty
  a_duty_on: assert property (p_duty_on)
    else $error("on time does not show level bit");

  property p_static_nib;
    @(posedge clk) disable iff (reset)
    state_reg.sh_int[0] == `LPI_STATIC_NIB
      |=> pin_oe[0] == ~$past(state_reg.sh_level[0]);
  endproperty
  a_static_nib: assert property (p_static_nib)
    else $error("static setting toggles");

  property p_global_all;
    @(posedge clk) disable iff (reset)
    boundary && global_enable
      |=> state_reg.sh_int ==
          {`LPI_NUM_OUT{$past(state_reg.master[`LPI_GLB_HI:`LPI_GLB_LO])}};
  endproperty
  a_global_all: assert property (p_global_all)
    else $error("global value not applied to all outputs");

  property p_extra_out;
    @(posedge clk) disable iff (reset)
    boundary |=> state_reg.sh_int[`LPI_EXTRA_IX] ==
      $past(state_reg.master[`LPI_GLB_HI:`LPI_GLB_LO]);
  endproperty
  a_extra_out: assert property (p_extra_out)
    else $error("extra output not on shared nibble");

  property p_indiv;
    @(posedge clk) disable iff (reset)
    boundary && !global_enable
      |=> state_reg.sh_int[3] == $past(state_reg.int_regs[1][7:4]);
  endproperty
  a_indiv: assert property (p_indiv)
    else $error("individual field not used");

  property p_blink_sel;
    @(posedge clk) disable iff (reset)
    boundary |=> state_reg.sh_level ==
      $past(blink.enable && blink.flip ? blink.phase1 : blink.phase0);
  endproperty
  a_blink_sel: assert property (p_blink_sel)
    else $error("wrong phase set for level");

  property p_int_write;
    @(posedge clk) disable iff (reset)
    reg_req.wr && reg_req.addr == `LPI_ADDR_INT_FIRST
      |=> state_reg.int_regs[0] == $past(reg_req.wdata) ##1
          reg_rd_data == $past(state_reg.int_regs[0]) ||
          $past(reg_req.addr) != `LPI_ADDR_INT_FIRST;
  endproperty
  a_int_write: assert property (p_int_write)
    else $error("intensity register write lost");

  property p_master_wr;
    @(posedge clk) disable iff (reset)
    reg_req.wr && reg_req.addr == `LPI_ADDR_MASTER
      |=> state_reg.master == $past(reg_req.wdata);
  endproperty
  a_master_wr: assert property (p_master_wr)
    else $error("master register write lost");

endmodule
`default_nettype wire

// *** sim/lpi_led_load.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lpi_defines.svh"

module lpi_led_load (
  input  wire logic [`LPI_NUM_OUT-1:0] pin_out,
  input  wire logic [`LPI_NUM_OUT-1:0] pin_oe,
  output logic [`LPI_NUM_OUT-1:0]      pad
);
  // Pull-up load: a released pin reads high, never the last driven value
  always_comb begin
    for (int i = 0; i < `LPI_NUM_OUT; i++) begin
      pad[i] = pin_oe[i] ? pin_out[i] : 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lpi_defines.svh"
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t %s", $time, m); end end

module tb;
  logic                    clk = 1'b0;
  logic                    reset = 1'b1;
  lpi_pkg::lpi_reg_req_s   req = '0;
  logic                    glb = 1'b0;
  lpi_pkg::lpi_blink_s     blk = '0;
  logic [7:0]              rd;
  logic [`LPI_NUM_OUT-1:0] p_out;
  logic [`LPI_NUM_OUT-1:0] p_oe;
  logic [`LPI_NUM_OUT-1:0] pad;
  logic                    run;
  int                      miscompares = 0;
  int                      n_compared = 0;
  int                      seed = 38908;
  logic [7:0]              mst;
  logic [7:0]              iregs [8];

  always #25 clk = ~clk;

  lpi_top uut (
    .clk          (clk),
    .reset        (reset),
    .reg_req      (req),
    .global_enable(glb),
    .blink        (blk),
    .reg_rd_data  (rd),
    .pin_out      (p_out),
    .pin_oe       (p_oe),
    .osc_run      (run)
  );

  lpi_led_load load (
    .pin_out(p_out),
    .pin_oe (p_oe),
    .pad    (pad)
  );

  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    req.addr <= a;
    @(posedge clk);
    #1;
    `CHK(rd, e, "register read")
  endtask

  // Expected pin_oe; pad is its inverse through the pull-up
  function automatic logic exp_oe(int i, int s, int c);
    logic [3:0] m;
    logic [3:0] n;
    logic       lvl;
    m = mst[7:4];
    n = (glb || i == `LPI_EXTRA_IX) ? mst[3:0] : iregs[i / 2][4 * (i % 2) +: 4];
    lvl = (blk.enable && blk.flip) ? blk.phase1[i] : blk.phase0[i];
    if (m == 4'h0 || n == 4'hF) return ~lvl;
    return (s < m && c <= n) ? ~lvl : lvl;
  endfunction

  task automatic pins_chk(int s, int c);
    for (int i = 0; i < `LPI_NUM_OUT; i++) begin
      `CHK({p_oe[i], pad[i]}, {exp_oe(i, s, c), ~exp_oe(i, s, c)}, "pin level")
    end
  endtask

  task automatic levels(input logic g, input logic be, input logic bf);
    @(posedge clk);
    glb <= g;
    blk.enable <= be;
    blk.flip <= bf;
    blk.phase0 <= 17'($random(seed));
    blk.phase1 <= 17'($random(seed));
  endtask

  task automatic pwm_run(input logic g, input logic be, input logic bf);
    wr(8'h0E, 8'h00);
    levels(g, be, bf);
    for (int k = 0; k < 8; k++) iregs[k] = 8'($random(seed));
    // Corners: static, minimum and maximum PWM values side by side
    iregs[0] = 8'h0F;
    iregs[1][3:0] = 4'hE;
    for (int k = 0; k < 8; k++) wr(8'h10 + 8'(k), iregs[k]);
    for (int k = 0; k < 8; k++) rd_chk(8'h10 + 8'(k), iregs[k]);
    mst = {4'h2, 4'($random(seed))};
    wr(8'h0E, mst);
    repeat (300) @(posedge clk);
    for (int st = 0; st < 34; st++) begin
      #1;
      pins_chk(st / 16, st % 16);
      `CHK(run, 1'b1, "timebase stopped")
      // Mid-period rewrite must not reach the pins before the boundary
      if (st == 5) wr(8'h10, ~iregs[0]);
      repeat (st == 5 ? 623 : 625) @(posedge clk);
    end
    $display("test pwm global=%0b blink=%0b done", g, be);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    mst = 8'h00;
    rd_chk(8'h0E, 8'h00);
    for (int k = 0; k < 8; k++) rd_chk(8'h10 + 8'(k), 8'h00);
    wr(8'h0F, 8'hAA);
    rd_chk(8'h0F, 8'h00);
    rd_chk(8'h18, 8'h00);
    $display("test registers done");
    for (int r = 0; r < 4; r++) begin
      // Flip alternates so enable with phase 0 selected is also seen
      levels(r[0], r[1], ~r[0]);
      for (int k = 0; k < 8; k++) iregs[k] = 8'($random(seed));
      wr(8'h10 + 8'(r), iregs[r]);
      mst = {4'h0, 4'($random(seed))};
      wr(8'h0E, mst);
      repeat (4) @(posedge clk);
      #1;
      pins_chk(0, 0);
      `CHK(run, 1'b0, "timebase running")
    end
    $display("test static done");
    pwm_run(1'b0, 1'b0, 1'b1);
    pwm_run(1'b1, 1'b1, 1'b1);
    wr(8'h0E, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    `CHK(run, 1'b0, "timebase not stopped")
    complete_run();
  end

  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    complete_run();
  end
endmodule
`default_nettype wire
